// ---- verilog/lin_cmd_pkg.sv ----
`default_nettype none
package lin_cmd_pkg;

  // ==========================================================
  // Frame kinds seen on the link
  typedef enum logic [3:0] {
    FK_IDLE, FK_WRITE1, FK_WRITE2, FK_WRITE3, FK_WRITE4,
    FK_READ5, FK_READ6, FK_PREP7, FK_PREP8, FK_SLEEP
  } frame_kind_t;

  // ==========================================================
  // Command codes
  localparam logic [6:0] CMD_READ_POSITION = 7'h00;
  localparam logic [6:0] CMD_READ_COMPLETE = 7'h01;
  localparam logic [6:0] CMD_READ_NVM = 7'h02;
  localparam logic [6:0] CMD_READ_SHORT = 7'h03;
  localparam logic [6:0] CMD_GO_SAFE = 7'h04;
  localparam logic [6:0] CMD_ABRUPT_HALT = 7'h05;
  localparam logic [6:0] CMD_ZERO_POSITION = 7'h06;
  localparam logic [6:0] CMD_TWO_TARGET = 7'h08;
  localparam logic [6:0] CMD_LOAD_DRIVE = 7'h09;
  localparam logic [6:0] CMD_BURN_NVM = 7'h10;
  localparam logic [6:0] CMD_LOAD_STALL = 7'h16;
  localparam logic [6:0] CMD_MOVE_TARGET = 7'h0B;
  localparam logic [6:0] CMD_COMPACT_1 = 7'h0C;
  localparam logic [6:0] CMD_COMPACT_2 = 7'h0D;
  localparam logic [6:0] CMD_COMPACT_4 = 7'h0E;
  localparam logic [6:0] CMD_MOVE_AND_TUNE = 7'h2F;
  localparam logic [6:0] CMD_RAMPED_HALT = 7'h0F;

  // ==========================================================
  // Frame layout
  localparam int BYTE_W = 8;
  localparam int FRAME_BYTES = 8;
  localparam int DATA_W = BYTE_W * FRAME_BYTES;
  localparam int MARK_BIT = 7;
  localparam logic [7:0] PREP_APP_MARK = 8'h80;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [1:0] DIRECT4_MARK = 2'h2;
  localparam logic [3:0] LEN_SHORT = 4'h2;
  localparam logic [3:0] LEN_POSITION = 4'h4;
  localparam logic [3:0] LEN_LONG = 4'h8;

  // ==========================================================
  // Position resolution per stepping mode
  localparam logic [15:0] RES_MASK_0 = 16'hFFF8;
  localparam logic [15:0] RES_MASK_1 = 16'hFFFC;
  localparam logic [15:0] RES_MASK_2 = 16'hFFFE;
  localparam logic [15:0] RES_MASK_3 = 16'hFFFF;

  // ==========================================================
  // Host register map
  localparam logic [7:0] REG_FRAME = 8'h00;
  localparam logic [7:0] REG_DATA_LO = 8'h04;
  localparam logic [7:0] REG_DATA_HI = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RSP_LO = 8'h10;
  localparam logic [7:0] REG_RSP_HI = 8'h14;
  localparam int FRAME_KIND_LSB = 0;
  localparam int FRAME_ID_LSB = 8;
  localparam int STATUS_LEN_LSB = 8;

  function automatic logic cmd_allowed(input frame_kind_t kind, input logic [6:0] code);
    logic ok;
    ok = 1'b0;
    unique case (code)
      CMD_GO_SAFE, CMD_ABRUPT_HALT, CMD_ZERO_POSITION, CMD_RAMPED_HALT:
        ok = (kind == FK_WRITE1);
      CMD_TWO_TARGET, CMD_LOAD_DRIVE, CMD_BURN_NVM, CMD_LOAD_STALL:
        ok = (kind == FK_WRITE4);
      CMD_MOVE_TARGET:
        ok = (kind == FK_WRITE1) || (kind == FK_WRITE3) || (kind == FK_WRITE4);
      CMD_COMPACT_1, CMD_COMPACT_2, CMD_COMPACT_4, CMD_MOVE_AND_TUNE:
        ok = (kind == FK_WRITE2);
      default:
        ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic [15:0] resolve_position(input logic [15:0] pos,
                                                   input logic [1:0] mode);
    logic [15:0] mask;
    mask = RES_MASK_3;
    unique case (mode)
      2'h0: mask = RES_MASK_0;
      2'h1: mask = RES_MASK_1;
      2'h2: mask = RES_MASK_2;
      2'h3: mask = RES_MASK_3;
    endcase
    return pos & mask;
  endfunction

endpackage
`default_nettype wire

// ---- verilog/lin_cmd_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface lin_cmd_if;
  // Frame from master, one cycle
  logic frm_valid;
  lin_cmd_pkg::frame_kind_t frm_kind;
  logic [5:0] frm_id;
  logic [lin_cmd_pkg::DATA_W-1:0] frm_data;
  // In-frame response from the node
  logic rsp_valid;
  logic [3:0] rsp_len;
  logic [lin_cmd_pkg::DATA_W-1:0] rsp_data;

  modport device (input frm_valid, frm_kind, frm_id, frm_data,
                  output rsp_valid, rsp_len, rsp_data);
  modport host (output frm_valid, frm_kind, frm_id, frm_data,
                input rsp_valid, rsp_len, rsp_data);
endinterface
`default_nettype wire

// ---- verilog/lin_status_packer.sv ----
`timescale 1ns/1ps
`default_nettype none
module lin_status_packer (
  // Node state
  input wire logic end_switch_state,
  input wire logic [6:0] node_addr,
  input wire logic [15:0] position,
  input wire logic [7:0] state_byte,
  input wire logic [7:0] extra_byte,
  // Packed answers, first data byte lowest
  output logic [lin_cmd_pkg::DATA_W-1:0] position_bytes,
  output logic [lin_cmd_pkg::DATA_W-1:0] short_bytes
);
  localparam int B = lin_cmd_pkg::BYTE_W;
  logic [7:0] head;

  assign head = {end_switch_state, node_addr};
  // RULE19 byte order
  assign position_bytes = {{3{lin_cmd_pkg::FILL_BYTE}}, extra_byte, state_byte,
                           position[B-1:0], position[2*B-1:B], head};
  // RULE22 same status byte
  assign short_bytes = {{6{lin_cmd_pkg::FILL_BYTE}}, state_byte, head};
endmodule
`default_nettype wire

// ---- verilog/lin_cmd_device.sv ----
// Functional notes
// RULE1 - Position read 0x00: prep 7/8, read 5/6
// RULE2 - Complete state 0x01: prep 7/8, read 6
// RULE3 - NVM readback 0x02: prep 7/8, read 6
// RULE4 - Short state 0x03: direct read 5
// RULE5 - 0x04 in write 1: go safe
// RULE6 - 0x05 abrupt halt, 0x0F ramped halt
// RULE7 - 0x06 in write 1: zero position
// RULE8 - 0x08 in write 4: two-target move
// RULE9 - 0x09 in write 4: load drive params
// RULE10 - 0x10 in write 4: burn NVM byte
// RULE11 - 0x16 in write 4: load stall detect
// RULE12 - 0x0B move accepted in write 1,3,4
// RULE13 - 0x0C/0D/0E write 2 compact targets
// RULE14 - 0x2F write 2 moves and tunes
// RULE15 - Sleep if permitted, else stop
// RULE16 - All-node bit zero ignores address
// RULE17 - Position signed, unresolved bits zero
// RULE18 - Position read clears no flag
// RULE19 - Type 5 answer: four bytes, marked
// RULE20 - Master gives each node direct ID
// RULE21 - Master prepares indirect read, then type 6
// RULE22 - Status byte equals short state
// RULE23 - Dynamic IDs for 2/4/8 byte writes
// RULE24 - Unknown commands are ignored
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lin_cmd_device #(
  parameter int ADDR_W = 7
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Link
  lin_cmd_if.device link,
  // Node setup
  input wire logic [ADDR_W-1:0] node_addr,
  input wire logic [5:0] pos_direct_id,
  input wire logic [5:0] state_direct_id,
  input wire logic sleep_permit,
  // Motion and flag state
  input wire logic end_switch_state,
  input wire logic [15:0] current_position,
  input wire logic [1:0] step_mode,
  input wire logic logic_supply_reset_flag,
  input wire logic missed_step_flag,
  input wire logic coil_fault_flag,
  input wire logic undervoltage_flag,
  input wire logic thermal_shutdown_flag,
  input wire logic thermal_warning_flag,
  input wire logic [1:0] temp_level,
  input wire logic [7:0] extra_state_byte,
  // Long answers supplied by the state store
  input wire logic [lin_cmd_pkg::DATA_W-1:0] long_rsp_data,
  // Command pulses to motion control
  output logic go_safe_target_cmd,
  output logic abrupt_halt_cmd,
  output logic ramped_halt_cmd,
  output logic zero_position_cmd,
  output logic two_target_move_cmd,
  output logic load_drive_params_cmd,
  output logic burn_nvm_byte_cmd,
  output logic load_stall_detect_cmd,
  output logic move_to_target_cmd,
  output logic compact_target_cmd,
  output logic move_and_tune_cmd,
  output logic enter_sleep,
  output logic enter_stop,
  output logic [lin_cmd_pkg::DATA_W-1:0] cmd_payload,
  // Read requests to the state store
  output logic long_read_req,
  output logic [6:0] long_read_code,
  output logic flag_clear_req
);
  localparam int B = lin_cmd_pkg::BYTE_W;
  localparam int M = lin_cmd_pkg::MARK_BIT;

  // Elaboration check: packer and frame layout assume 7-bit node numbers
  if (ADDR_W != 7) begin
    $error("node address must be 7 bits");
  end

  // ==========================================================
  // Frame decode
  logic [7:0] d1, d2, d3;
  logic [6:0] wr_code;
  logic wr_kind;
  logic wr_hit;
  logic prep_ok;
  logic [6:0] prep_code;
  logic [7:0] state_byte;
  logic [lin_cmd_pkg::DATA_W-1:0] pos_bytes, short_bytes;
  logic [6:0] pend_code;
  logic pend_valid;

  assign d1 = link.frm_data[B-1:0];
  assign d2 = link.frm_data[2*B-1:B];
  assign d3 = link.frm_data[3*B-1:2*B];
  assign wr_code = d1[6:0];
  // RULE23 writes on any dynamic ID
  assign wr_kind = link.frm_kind inside {lin_cmd_pkg::FK_WRITE1, lin_cmd_pkg::FK_WRITE2,
                                         lin_cmd_pkg::FK_WRITE3, lin_cmd_pkg::FK_WRITE4};
  // RULE16 all-node bit
  // RULE24 unsupported code ignored
  assign wr_hit = link.frm_valid && wr_kind &&
                  lin_cmd_pkg::cmd_allowed(link.frm_kind, wr_code) &&
                  (!d2[M] || d2[6:0] == node_addr);

  // Type 8 carries the application mark first, so code and address shift one byte
  always_comb begin
    prep_ok = 1'b0;
    prep_code = d1[6:0];
    if (link.frm_valid && link.frm_kind == lin_cmd_pkg::FK_PREP7) begin
      prep_ok = d1[M] && d2[M] && d2[6:0] == node_addr;
    end else if (link.frm_valid && link.frm_kind == lin_cmd_pkg::FK_PREP8) begin
      prep_code = d2[6:0];
      prep_ok = d1 == lin_cmd_pkg::PREP_APP_MARK && d2[M] && d3[M] &&
                d3[6:0] == node_addr;
    end
    // RULE1 RULE2 RULE3 prep-read codes
    if (!(prep_code inside {lin_cmd_pkg::CMD_READ_POSITION, lin_cmd_pkg::CMD_READ_COMPLETE,
                            lin_cmd_pkg::CMD_READ_NVM})) begin
      prep_ok = 1'b0;
    end
  end

  // RULE22 status byte layout
  assign state_byte = {logic_supply_reset_flag, missed_step_flag, coil_fault_flag,
                       undervoltage_flag, thermal_shutdown_flag, thermal_warning_flag,
                       temp_level};

  lin_status_packer packer (
    .end_switch_state(end_switch_state),
    .node_addr(node_addr),
    // RULE17 mask unresolved bits
    .position(lin_cmd_pkg::resolve_position(current_position, step_mode)),
    .state_byte(state_byte),
    .extra_byte(extra_state_byte),
    .position_bytes(pos_bytes),
    .short_bytes(short_bytes)
  );

  // ==========================================================
  // Write command pulses
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      go_safe_target_cmd <= 1'b0;
      abrupt_halt_cmd <= 1'b0;
      ramped_halt_cmd <= 1'b0;
      zero_position_cmd <= 1'b0;
      two_target_move_cmd <= 1'b0;
      load_drive_params_cmd <= 1'b0;
      burn_nvm_byte_cmd <= 1'b0;
      load_stall_detect_cmd <= 1'b0;
      move_to_target_cmd <= 1'b0;
      compact_target_cmd <= 1'b0;
      move_and_tune_cmd <= 1'b0;
      cmd_payload <= '0;
    end else begin
      // RULE5 go safe
      go_safe_target_cmd <= wr_hit && wr_code == lin_cmd_pkg::CMD_GO_SAFE;
      // RULE6 two halts
      abrupt_halt_cmd <= wr_hit && wr_code == lin_cmd_pkg::CMD_ABRUPT_HALT;
      ramped_halt_cmd <= wr_hit && wr_code == lin_cmd_pkg::CMD_RAMPED_HALT;
      // RULE7 zero here
      zero_position_cmd <= wr_hit && wr_code == lin_cmd_pkg::CMD_ZERO_POSITION;
      // RULE8 two targets
      two_target_move_cmd <= wr_hit && wr_code == lin_cmd_pkg::CMD_TWO_TARGET;
      // RULE9 drive params
      load_drive_params_cmd <= wr_hit && wr_code == lin_cmd_pkg::CMD_LOAD_DRIVE;
      // RULE10 NVM burn
      burn_nvm_byte_cmd <= wr_hit && wr_code == lin_cmd_pkg::CMD_BURN_NVM;
      // RULE11 stall params
      load_stall_detect_cmd <= wr_hit && wr_code == lin_cmd_pkg::CMD_LOAD_STALL;
      // RULE12 target move
      move_to_target_cmd <= wr_hit && wr_code == lin_cmd_pkg::CMD_MOVE_TARGET;
      // RULE13 compact targets
      compact_target_cmd <= wr_hit && wr_code inside {lin_cmd_pkg::CMD_COMPACT_1,
                                                      lin_cmd_pkg::CMD_COMPACT_2,
                                                      lin_cmd_pkg::CMD_COMPACT_4};
      // RULE14 move and tune
      move_and_tune_cmd <= wr_hit && wr_code == lin_cmd_pkg::CMD_MOVE_AND_TUNE;
      // Payload only moves on an accepted write, so a rejected frame leaves it intact
      if (wr_hit) begin
        cmd_payload <= link.frm_data;
      end
    end
  end

  // ==========================================================
  // Sleep handling
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      enter_sleep <= 1'b0;
      enter_stop <= 1'b0;
    end else begin
      // RULE15 permit selects
      enter_sleep <= link.frm_valid && link.frm_kind == lin_cmd_pkg::FK_SLEEP && sleep_permit;
      enter_stop <= link.frm_valid && link.frm_kind == lin_cmd_pkg::FK_SLEEP && !sleep_permit;
    end
  end

  // ==========================================================
  // Pending indirect read
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pend_valid <= 1'b0;
      pend_code <= lin_cmd_pkg::CMD_READ_POSITION;
      long_read_req <= 1'b0;
      long_read_code <= lin_cmd_pkg::CMD_READ_POSITION;
    end else begin
      long_read_req <= 1'b0;
      if (prep_ok) begin
        pend_valid <= 1'b1;
        pend_code <= prep_code;
        // Store gets a cycle of warning so long data is ready by the type 6 read
        long_read_req <= prep_code != lin_cmd_pkg::CMD_READ_POSITION;
        long_read_code <= prep_code;
      end else if (link.frm_valid && link.frm_kind == lin_cmd_pkg::FK_READ6) begin
        pend_valid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // In-frame responses
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      link.rsp_valid <= 1'b0;
      link.rsp_len <= '0;
      link.rsp_data <= '0;
      flag_clear_req <= 1'b0;
    end else begin
      link.rsp_valid <= 1'b0;
      flag_clear_req <= 1'b0;
      if (link.frm_valid && link.frm_kind == lin_cmd_pkg::FK_READ5) begin
        // RULE19 direct four-byte ID
        if (link.frm_id == pos_direct_id &&
            link.frm_id[5:4] == lin_cmd_pkg::DIRECT4_MARK) begin
          link.rsp_valid <= 1'b1;
          link.rsp_len <= lin_cmd_pkg::LEN_POSITION;
          link.rsp_data <= pos_bytes;
        // RULE4 direct short read
        end else if (link.frm_id == state_direct_id) begin
          link.rsp_valid <= 1'b1;
          link.rsp_len <= lin_cmd_pkg::LEN_SHORT;
          link.rsp_data <= short_bytes;
        end
      end else if (link.frm_valid && link.frm_kind == lin_cmd_pkg::FK_READ6 && pend_valid) begin
        link.rsp_valid <= 1'b1;
        link.rsp_len <= lin_cmd_pkg::LEN_LONG;
        // RULE18 no flag clear
        if (pend_code == lin_cmd_pkg::CMD_READ_POSITION) begin
          link.rsp_data <= pos_bytes;
        end else begin
          link.rsp_data <= long_rsp_data;
          // RULE2 complete state clears
          flag_clear_req <= pend_code == lin_cmd_pkg::CMD_READ_COMPLETE;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/lin_cmd_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module lin_cmd_host #(
  parameter int REG_W = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_W-1:0] reg_rdata,
  // Link
  lin_cmd_if.host link
);
  // Elaboration check: two data words must fill one 64-bit frame
  if (REG_W != 32) begin
    $error("register port must be 32 bits");
  end

  // ==========================================================
  // Frame launch
  logic [REG_W-1:0] data_lo, data_hi;
  logic rsp_got;
  logic [3:0] rsp_len;
  logic [lin_cmd_pkg::DATA_W-1:0] rsp_data;

  // Writing the frame register sends; data words must be written first
  // RULE20 RULE21 software picks IDs and prep layout
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      data_lo <= '0;
      data_hi <= '0;
      link.frm_valid <= 1'b0;
      link.frm_kind <= lin_cmd_pkg::FK_IDLE;
      link.frm_id <= '0;
      link.frm_data <= '0;
    end else begin
      link.frm_valid <= 1'b0;
      if (reg_wr && reg_addr == lin_cmd_pkg::REG_DATA_LO) begin
        data_lo <= reg_wdata;
      end
      if (reg_wr && reg_addr == lin_cmd_pkg::REG_DATA_HI) begin
        data_hi <= reg_wdata;
      end
      if (reg_wr && reg_addr == lin_cmd_pkg::REG_FRAME) begin
        link.frm_valid <= 1'b1;
        link.frm_kind <= lin_cmd_pkg::frame_kind_t'(reg_wdata[lin_cmd_pkg::FRAME_KIND_LSB +: 4]);
        link.frm_id <= reg_wdata[lin_cmd_pkg::FRAME_ID_LSB +: 6];
        link.frm_data <= {data_hi, data_lo};
      end
    end
  end

  // ==========================================================
  // Response capture; a new answer wins over a status read clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rsp_got <= 1'b0;
      rsp_len <= '0;
      rsp_data <= '0;
    end else if (link.rsp_valid) begin
      rsp_got <= 1'b1;
      rsp_len <= link.rsp_len;
      rsp_data <= link.rsp_data;
    end else if (reg_rd && reg_addr == lin_cmd_pkg::REG_STATUS) begin
      rsp_got <= 1'b0;
    end
  end

  // ==========================================================
  // Read port; unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        lin_cmd_pkg::REG_FRAME:
          reg_rdata <= REG_W'({link.frm_id, 4'h0, 4'(link.frm_kind)});
        lin_cmd_pkg::REG_DATA_LO: reg_rdata <= data_lo;
        lin_cmd_pkg::REG_DATA_HI: reg_rdata <= data_hi;
        lin_cmd_pkg::REG_STATUS:
          reg_rdata <= REG_W'({rsp_len, 7'h00, rsp_got});
        lin_cmd_pkg::REG_RSP_LO: reg_rdata <= rsp_data[REG_W-1:0];
        lin_cmd_pkg::REG_RSP_HI: reg_rdata <= rsp_data[2*REG_W-1:REG_W];
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule
`default_nettype wire

// ---- test/lin_cmd_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module lin_cmd_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Link signals
  input wire logic frm_valid,
  input wire lin_cmd_pkg::frame_kind_t frm_kind,
  input wire logic [5:0] frm_id,
  input wire logic rsp_valid,
  input wire logic [3:0] rsp_len,
  input wire logic [lin_cmd_pkg::DATA_W-1:0] rsp_data
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  wire [1:0] id_mark = frm_id[5:4];
  // ========================================
  // Frame sequences
  sequence s_read5_pos;
    frm_valid && frm_kind == lin_cmd_pkg::FK_READ5 && id_mark == lin_cmd_pkg::DIRECT4_MARK;
  endsequence
  sequence s_read6;
    frm_valid && frm_kind == lin_cmd_pkg::FK_READ6;
  endsequence
  sequence s_no_read;
    frm_valid && frm_kind != lin_cmd_pkg::FK_READ5 && frm_kind != lin_cmd_pkg::FK_READ6;
  endsequence
  // ========================================
  // Answers
  a_answer_has_frame: assert property (rsp_valid |-> $past(frm_valid))
    else $error("answer without a frame");
  a_pos_four_bytes: assert property (s_read5_pos ##1 rsp_valid |-> rsp_len == 4'h4)
    else $error("position answer length wrong");
  a_four_marked: assert property (rsp_valid && rsp_len == 4'h4 |-> $past(id_mark) == 2'h2)
    else $error("four byte answer to unmarked id");
  a_read6_eight: assert property (s_read6 ##1 rsp_valid |-> rsp_len == 4'h8)
    else $error("reading frame six length wrong");
  a_other_silent: assert property (s_no_read |=> !rsp_valid)
    else $error("answer to a non reading frame");
  a_single_pulse: assert property (rsp_valid && !frm_valid |=> !rsp_valid)
    else $error("answer pulse too long");
  a_data_holds: assert property (!rsp_valid && $past(rstn) |-> $stable(rsp_data))
    else $error("answer data moved");
  a_len_holds: assert property (!rsp_valid && $past(rstn) |-> $stable(rsp_len))
    else $error("answer length moved");
  a_len_legal: assert property (rsp_valid |-> rsp_len inside {4'h2, 4'h4, 4'h8})
    else $error("answer length illegal");
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED at %0t: got %h exp %h", $time, (a), (e)); end end
module tb_top;
  logic sys_clk, rstn, reg_wr, reg_rd, sleep_permit;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, r;
  logic [1:0] step_mode;
  logic [14:0] got;
  logic end_sw = 1'b1;
  logic [6:0] node = 7'h15;
  logic [15:0] cur_pos = 16'h8ABF;
  logic [1:0] temp = 2'h2;
  logic [5:0] flags = 6'h2D;
  logic [7:0] extra = 8'h5C;
  logic [63:0] long_data = 64'h0123_4567_89AB_CDEF;
  wire [31:0] reg_rdata;
  wire [63:0] payload;
  wire [6:0] long_code;
  wire [14:0] pls;
  int n_fail = 0;
  int total_checks = 0;
  lin_cmd_if link ();
  lin_cmd_host lin_cmd_host_i (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link(link.host));
  lin_cmd_device lin_cmd_device_i (.sys_clk(sys_clk), .rstn(rstn), .link(link.device),
    .node_addr(node), .pos_direct_id(6'h2A), .state_direct_id(6'h05),
    .sleep_permit(sleep_permit), .end_switch_state(end_sw), .current_position(cur_pos),
    .step_mode(step_mode), .logic_supply_reset_flag(flags[5]),
    .missed_step_flag(flags[4]), .coil_fault_flag(flags[3]), .undervoltage_flag(flags[2]),
    .thermal_shutdown_flag(flags[1]), .thermal_warning_flag(flags[0]), .temp_level(temp),
    .extra_state_byte(extra), .long_rsp_data(long_data), .go_safe_target_cmd(pls[14]),
    .abrupt_halt_cmd(pls[13]), .ramped_halt_cmd(pls[12]), .zero_position_cmd(pls[11]),
    .two_target_move_cmd(pls[10]), .load_drive_params_cmd(pls[9]),
    .burn_nvm_byte_cmd(pls[8]), .load_stall_detect_cmd(pls[7]),
    .move_to_target_cmd(pls[6]), .compact_target_cmd(pls[5]), .move_and_tune_cmd(pls[4]),
    .enter_sleep(pls[3]), .enter_stop(pls[2]), .cmd_payload(payload),
    .long_read_req(pls[1]), .long_read_code(long_code), .flag_clear_req(pls[0]));
  lin_cmd_sva lin_cmd_sva_i (.sys_clk(sys_clk), .rstn(rstn), .frm_valid(link.frm_valid),
    .frm_kind(link.frm_kind), .frm_id(link.frm_id), .rsp_valid(link.rsp_valid),
    .rsp_len(link.rsp_len), .rsp_data(link.rsp_data));
  // ========================================
  // Register port and frames
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask
  // Pulses are gathered over a few cycles so a late one still shows
  task automatic send(input logic [3:0] k, input logic [5:0] id, input logic [63:0] d);
    got = '0;
    wr(lin_cmd_pkg::REG_DATA_LO, d[31:0]);
    wr(lin_cmd_pkg::REG_DATA_HI, d[63:32]);
    wr(lin_cmd_pkg::REG_FRAME, {18'h0, id, 4'h0, k});
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    repeat (4) begin
      @(posedge sys_clk);
      #1 got = got | pls;
    end
  endtask
  // ========================================
  // Scenarios
  // command map
  task automatic t_writes();
    logic [3:0] kn[18] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h4, 4'h4, 4'h4, 4'h4, 4'h1, 4'h3,
      4'h4, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h1, 4'h4};
    logic [6:0] cd[18] = '{7'h04, 7'h05, 7'h06, 7'h0F, 7'h08, 7'h09, 7'h10, 7'h16, 7'h0B,
      7'h0B, 7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h2F, 7'h04, 7'h07, 7'h0C};
    int bn[18] = '{14, 13, 11, 12, 10, 9, 8, 7, 6, 6, 6, 5, 5, 5, 4, -1, -1, -1};
    logic [63:0] d, last;
    last = '0;
    for (int i = 0; i < 18; i++) begin
      d = {24'hC0DE00, 8'(i), 24'h0, 1'b0, cd[i]};
      send(kn[i], 6'h10, d);
      if (bn[i] >= 0) last = d;
      `CHK(got, (bn[i] < 0) ? 15'h0000 : 15'h0001 << bn[i])
      `CHK(payload, last)
    end
    rd(lin_cmd_pkg::REG_DATA_HI);
    `CHK(r, d[63:32])
    rd(lin_cmd_pkg::REG_FRAME);
    `CHK(r, 32'h0000_1004)
    $display("test writes done");
  endtask
  task automatic t_addr_sleep();
    logic [7:0] b2[3] = '{8'h95, 8'h96, 8'h16};
    for (int i = 0; i < 3; i++) begin
      send(4'h1, 6'h10, {48'h0, b2[i], 8'h05});
      `CHK(got, (i == 1) ? 15'h0000 : 15'h2000)
    end
    for (int p = 0; p < 2; p++) begin
      @(posedge sys_clk);
      sleep_permit <= p[0];
      send(4'h9, 6'h10, 64'h0);
      `CHK(got, p[0] ? 15'h0008 : 15'h0004)
    end
    $display("test address and sleep done");
  endtask
  task automatic t_read5();
    logic [15:0] p;
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk);
      step_mode <= m[1:0];
      p = cur_pos & (16'hFFFF << (3 - m));
      send(4'h5, 6'h2A, 64'h0);
      `CHK(got, 15'h0000)
      rd(8'h0C);
      `CHK(r, 32'h0000_0401)
      rd(8'h10);
      `CHK(r, {flags, temp, p[7:0], p[15:8], end_sw, node})
    end
    send(4'h5, 6'h05, 64'h0);
    rd(8'h10);
    `CHK(r, {16'hFFFF, flags, temp, end_sw, node})
    rd(8'h0C);
    send(4'h5, 6'h2B, 64'h0);
    rd(8'h0C);
    `CHK(r, 32'h0000_0200)
    $display("test direct read done");
  endtask
  task automatic t_read6();
    logic [3:0] kn[4] = '{4'h7, 4'h8, 4'h7, 4'h7};
    logic [63:0] pd[4] = '{{48'hFFFF_FFFF_FFFF, 8'h95, 8'h80},
      {40'hFF_FFFF_FFFF, 8'h95, 8'h80, 8'h80},
      {48'hFFFF_FFFF_FFFF, 8'h95, 8'h81}, {48'hFFFF_FFFF_FFFF, 8'h95, 8'h82}};
    logic [63:0] e;
    for (int i = 0; i < 4; i++) begin
      e = (i < 2) ? {24'hFF_FFFF, extra, flags, temp, cur_pos[7:0], cur_pos[15:8],
        end_sw, node} : long_data;
      send(kn[i], 6'h3C, pd[i]);
      `CHK(got, (i < 2) ? 15'h0000 : 15'h0002)
      if (i >= 2) `CHK(long_code, 7'(i - 1))
      send(4'h6, 6'h3D, 64'h0);
      // Flag clear request comes with the answer, only for the complete state read
      `CHK(got, (i == 2) ? 15'h0001 : 15'h0000)
      rd(8'h0C);
      `CHK(r, 32'h0000_0801)
      rd(8'h10);
      `CHK(r, e[31:0])
      rd(8'h14);
      `CHK(r, e[63:32])
    end
    send(4'h6, 6'h3D, 64'h0);
    rd(8'h0C);
    `CHK(r, 32'h0000_0800)
    $display("test prepared read done");
  endtask
  task automatic t_reset();
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(8'h14);
    `CHK(r, 32'h0000_0000)
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20);
    `CHK(r, 32'h0000_0000)
    `CHK(payload, 64'h0)
    $display("test reset done");
  endtask
  // ========================================
  // Run control
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    wrap_up();
  end
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    sleep_permit = 1'b0;
    step_mode = 2'h0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    t_writes();
    t_addr_sleep();
    t_read5();
    t_read6();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
